// *** gcs_defines.vh ***
// register offsets, field positions and reset values of the global config/status bank
`ifndef GCS_DEFINES_VH
`define GCS_DEFINES_VH

`define GCS_ADDR_W            7
`define GCS_ADDR_CONFIG       7'h00
`define GCS_ADDR_STATUS       7'h01
`define GCS_ADDR_UARTCNT      7'h02
`define GCS_RDATA_RESET       32'h00000000

`define GCS_CFG_W             18
`define GCS_CFG_RESET         18'h00000

`define GCS_CFG_DIAG_A_PP     12
`define GCS_CFG_DIAG_B_PP     13
`define GCS_CFG_SMALL_HYST    14
`define GCS_CFG_STOP_EN       15
`define GCS_CFG_DIRECT        16
`define GCS_CFG_TEST          17

`define GCS_ST_RESET          0
`define GCS_ST_DRV_ERR        1
`define GCS_ST_UNDERVOLT      2
`define GCS_ST_W              3
`define GCS_ST_RESET_VAL      3'h1

`define GCS_CNT_W             8
`define GCS_CNT_RESET         8'h00
`define GCS_CNT_ONE           8'h01

`define GCS_FREQ_W            20
`define GCS_HYST_SHIFT_WIDE   4
`define GCS_HYST_SHIFT_NARROW 5

`define GCS_COIL_W            9
`define GCS_COIL_A_LSB        0
`define GCS_COIL_B_LSB        16
`define GCS_HOLD_W            5
`define GCS_PROD_W            14
`define GCS_HOLD_SHIFT        5
`define GCS_TEST_SEL_W        2

`endif

// *** gcs_diag_pin.v ***
// one diagnostic pin with selectable open-collector or push-pull drive
`include "gcs_defines.vh"

module gcs_diag_pin (
	input  wire clk_i,
	input  wire nrst_i,
	input  wire push_pull_i,
	input  wire active_i,
	output wire pin_o,
	output wire pin_oe_o
);

	reg active_q;

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			active_q <= 1'b0;
		end else begin
			active_q <= active_i;
		end
	end

	// open collector only pulls low; push-pull drives active high always
	assign pin_o    = push_pull_i ? active_q : 1'b0;
	assign pin_oe_o = push_pull_i ? 1'b1 : active_q;

endmodule

// *** gcs_freq_compare.v ***
// step frequency threshold comparator with selectable hysteresis
`include "gcs_defines.vh"

module gcs_freq_compare (
	input  wire                   clk_i,
	input  wire                   nrst_i,
	input  wire                   small_hyst_i,
	input  wire [`GCS_FREQ_W-1:0] freq_i,
	input  wire [`GCS_FREQ_W-1:0] thresh_i,
	output reg                    above_o
);

	wire [`GCS_FREQ_W-1:0] hyst;
	wire [`GCS_FREQ_W:0]   upper;

	// window of 1/16 or 1/32 of threshold keeps the decision from chattering
	assign hyst  = small_hyst_i ? (thresh_i >> `GCS_HYST_SHIFT_NARROW) :
		(thresh_i >> `GCS_HYST_SHIFT_WIDE);
	assign upper = {1'b0, thresh_i} + {1'b0, hyst};

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			above_o <= 1'b0;
		end else if ({1'b0, freq_i} > upper) begin
			above_o <= 1'b1;
		end else if (freq_i < thresh_i - hyst) begin
			above_o <= 1'b0;
		end
	end

endmodule

// *** gcs_regs.v ***
// global configuration flags, global status flags and uart write counter
`include "gcs_defines.vh"

// Overview of operation
// - config bit 12 clear gives open-collector active-low diag A, set push-pull high.
// - config bit 13 does the same for diag B, the position compare pin.
// - frequency comparison hysteresis is 1/16, or 1/32 with hysteresis select set.
// - with bit 15 set, high on encoder-A input halts the sequencer.
// - bit 16 takes signed coil A/B currents directly from target position.
// - direct coil currents scale by hold current; automatic regulation is off.
// - status bit 0 reads one if reset occurred since the previous status read.
// - reset returns every register to its reset value except the diag A pin register, which it loads active.
// - status bit 1 flags driver shutdown; read clears it only once errors are gone.
// - status bit 2 flags pump undervoltage and disables the driver meanwhile.
// - 8-bit counter increments on each completed uart write.
// - reads leave the counter unchanged; it does not count in spi mode.
// - counter wraps from 255 to 0.
// - diag A is asserted low while reset is active, whatever the config.
module gcs_regs (
	input  wire                    clk_i,
	input  wire                    nrst_i,
	input  wire [`GCS_ADDR_W-1:0]  addr_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	input  wire [31:0]             wdata_i,
	output reg  [31:0]             rdata_o,
	input  wire                    uart_mode_i,
	input  wire                    uart_wr_done_i,
	input  wire                    overtemp_i,
	input  wire                    short_i,
	input  wire                    pump_undervolt_i,
	input  wire                    diag_a_event_i,
	input  wire                    diag_b_event_i,
	input  wire                    enc_a_step_in_pin_i,
	input  wire [31:0]             target_position_i,
	input  wire [`GCS_HOLD_W-1:0]  hold_current_i,
	input  wire [`GCS_FREQ_W-1:0]  step_freq_i,
	input  wire [`GCS_FREQ_W-1:0]  freq_thresh_i,
	input  wire [`GCS_TEST_SEL_W+1:0] test_signals_i,
	output wire                    diag_a_pin_o,
	output wire                    diag_a_pin_oe_o,
	output wire                    diag_b_pin_o,
	output wire                    diag_b_pin_oe_o,
	output wire                    freq_above_o,
	output reg                     seq_halt_o,
	output reg                     driver_enable_o,
	output reg                     direct_mode_o,
	output reg                     auto_current_en_o,
	output reg  [`GCS_COIL_W-1:0]  coil_a_o,
	output reg  [`GCS_COIL_W-1:0]  coil_b_o,
	output reg                     enc_n_dc_out_pin_o,
	output reg                     enc_n_dc_out_pin_oe_o,
	output wire [`GCS_CFG_W-1:0]   global_config_flags_o
);

	reg  [`GCS_CFG_W-1:0]  global_config_flags_q;
	reg  [`GCS_ST_W-1:0]   global_status_flags_q;
	reg  [`GCS_ST_W-1:0]   global_status_flags_d;
	reg  [`GCS_CNT_W-1:0]  uart_write_counter_q;
	wire                   drv_err_now;
	wire                   wr_cfg;
	wire                   rd_stat;

	// signed coil value times hold current, rescaled to coil width
	function [`GCS_COIL_W-1:0] scale_coil;
		input [`GCS_COIL_W-1:0] raw;
		input [`GCS_HOLD_W-1:0] hold;
		reg   [`GCS_PROD_W-1:0] prod;
		begin
			prod       = $signed(raw) * $signed({1'b0, hold});
			scale_coil = prod[`GCS_PROD_W-1:`GCS_HOLD_SHIFT];
		end
	endfunction

	assign wr_cfg      = wr_i && (addr_i == `GCS_ADDR_CONFIG);
	assign rd_stat     = rd_i && (addr_i == `GCS_ADDR_STATUS);
	assign drv_err_now = overtemp_i | short_i;
	assign global_config_flags_o = global_config_flags_q;

	// ----------------------------------------
	// configuration register
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			global_config_flags_q <= `GCS_CFG_RESET;
		end else if (wr_cfg) begin
			global_config_flags_q <= wdata_i[`GCS_CFG_W-1:0];
		end
	end

	// ----------------------------------------
	// status flags, read-clear with set priority
	// ----------------------------------------
	always @* begin
		global_status_flags_d = global_status_flags_q;
		if (rd_stat) begin
			global_status_flags_d[`GCS_ST_RESET] = 1'b0;
			if (!drv_err_now) begin
				global_status_flags_d[`GCS_ST_DRV_ERR] = 1'b0;
			end
			global_status_flags_d[`GCS_ST_UNDERVOLT] = 1'b0;
		end
		// events in the read cycle set again after the clear
		if (drv_err_now) begin
			global_status_flags_d[`GCS_ST_DRV_ERR] = 1'b1;
		end
		if (pump_undervolt_i) begin
			global_status_flags_d[`GCS_ST_UNDERVOLT] = 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			global_status_flags_q <= `GCS_ST_RESET_VAL;
		end else begin
			global_status_flags_q <= global_status_flags_d;
		end
	end

	// ----------------------------------------
	// uart write counter
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			uart_write_counter_q <= `GCS_CNT_RESET;
		end else if (uart_mode_i && uart_wr_done_i) begin
			// natural 8-bit overflow gives the wrap
			uart_write_counter_q <= uart_write_counter_q + `GCS_CNT_ONE;
		end
	end

	// ----------------------------------------
	// read data, sampled before the clear
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_o <= `GCS_RDATA_RESET;
		end else if (rd_i) begin
			if (addr_i == `GCS_ADDR_CONFIG) begin
				rdata_o <= {{(32-`GCS_CFG_W){1'b0}}, global_config_flags_q};
			end else if (addr_i == `GCS_ADDR_STATUS) begin
				rdata_o <= {{(32-`GCS_ST_W){1'b0}}, global_status_flags_q};
			end else if (addr_i == `GCS_ADDR_UARTCNT) begin
				rdata_o <= {{(32-`GCS_CNT_W){1'b0}}, uart_write_counter_q};
			end else begin
				rdata_o <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// motion and driver control
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			seq_halt_o        <= 1'b0;
			driver_enable_o   <= 1'b0;
			direct_mode_o     <= 1'b0;
			auto_current_en_o <= 1'b0;
			coil_a_o          <= {`GCS_COIL_W{1'b0}};
			coil_b_o          <= {`GCS_COIL_W{1'b0}};
		end else begin
			seq_halt_o <= global_config_flags_q[`GCS_CFG_STOP_EN] &
				enc_a_step_in_pin_i;
			driver_enable_o <= ~pump_undervolt_i & ~drv_err_now;
			direct_mode_o <= global_config_flags_q[`GCS_CFG_DIRECT];
			// automatic regulation makes no sense with host-set currents
			auto_current_en_o <= ~global_config_flags_q[`GCS_CFG_DIRECT];
			coil_a_o <= scale_coil(target_position_i[`GCS_COIL_A_LSB +: `GCS_COIL_W],
				hold_current_i);
			coil_b_o <= scale_coil(target_position_i[`GCS_COIL_B_LSB +: `GCS_COIL_W],
				hold_current_i);
		end
	end

	// ----------------------------------------
	// analog test output routing
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			enc_n_dc_out_pin_o    <= 1'b0;
			enc_n_dc_out_pin_oe_o <= 1'b0;
		end else begin
			// selector reaches the pin only if the host sets the test bit
			enc_n_dc_out_pin_oe_o <= global_config_flags_q[`GCS_CFG_TEST];
			enc_n_dc_out_pin_o <= test_signals_i[hold_current_i[`GCS_TEST_SEL_W-1:0]];
		end
	end

	// ----------------------------------------
	// diagnostic pins and comparator
	// ----------------------------------------
	// during reset the pin is forced active, so it shows reset in either mode
	gcs_diag_pin u_diag_a (
		.clk_i       (clk_i),
		.nrst_i      (1'b1),
		.push_pull_i (global_config_flags_q[`GCS_CFG_DIAG_A_PP]),
		.active_i    (diag_a_event_i | ~nrst_i),
		.pin_o       (diag_a_pin_o),
		.pin_oe_o    (diag_a_pin_oe_o)
	);

	gcs_diag_pin u_diag_b (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.push_pull_i (global_config_flags_q[`GCS_CFG_DIAG_B_PP]),
		.active_i    (diag_b_event_i),
		.pin_o       (diag_b_pin_o),
		.pin_oe_o    (diag_b_pin_oe_o)
	);

	gcs_freq_compare u_freq (
		.clk_i        (clk_i),
		.nrst_i       (nrst_i),
		.small_hyst_i (global_config_flags_q[`GCS_CFG_SMALL_HYST]),
		.freq_i       (step_freq_i),
		.thresh_i     (freq_thresh_i),
		.above_o      (freq_above_o)
	);

endmodule

// *** gcs_regs_chk.sv ***
// concurrent checks on the ports of the global config/status bank
`include "gcs_defines.vh"

module gcs_regs_chk (
	input wire logic                   clk_i,
	input wire logic                   nrst_i,
	input wire logic [`GCS_ADDR_W-1:0] addr_i,
	input wire logic                   rd_i,
	input wire logic                   pump_undervolt_i,
	input wire logic                   diag_a_event_i,
	input wire logic                   diag_b_event_i,
	input wire logic                   enc_a_step_in_pin_i,
	input wire logic                   diag_a_pin_o,
	input wire logic                   diag_a_pin_oe_o,
	input wire logic                   diag_b_pin_o,
	input wire logic                   diag_b_pin_oe_o,
	input wire logic                   seq_halt_o,
	input wire logic                   driver_enable_o,
	input wire logic                   direct_mode_o,
	input wire logic                   auto_current_en_o,
	input wire logic [31:0]            rdata_o,
	input wire logic [`GCS_CFG_W-1:0]  global_config_flags_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// pin mode follows the config bit of the same cycle, the level the event of the last one
	property p_diag_a_oc;
		!global_config_flags_o[12] && $past(diag_a_event_i) |-> diag_a_pin_oe_o && !diag_a_pin_o;
	endproperty
	property p_diag_a_pp;
		global_config_flags_o[12] |-> diag_a_pin_oe_o && diag_a_pin_o == $past(diag_a_event_i);
	endproperty
	property p_diag_b_oc;
		!global_config_flags_o[13] |-> !diag_b_pin_o && diag_b_pin_oe_o == $past(diag_b_event_i);
	endproperty
	property p_diag_b_pp;
		global_config_flags_o[13] |-> diag_b_pin_oe_o && diag_b_pin_o == $past(diag_b_event_i);
	endproperty
	property p_halt;
		seq_halt_o == $past(global_config_flags_o[15] && enc_a_step_in_pin_i);
	endproperty
	property p_drv_off;
		pump_undervolt_i |=> !driver_enable_o;
	endproperty
	// direct_mode_o and auto_current_en_o are both low in reset, so skip the first edge after release
	property p_direct;
		$past(nrst_i) |-> direct_mode_o == $past(global_config_flags_o[16])
			&& auto_current_en_o == !direct_mode_o;
	endproperty
	property p_uv_read;
		rd_i && addr_i == `GCS_ADDR_STATUS && $past(pump_undervolt_i) |=> rdata_o[2];
	endproperty
	property p_rst_diag;
		disable iff (1'b0) !nrst_i |=> diag_a_pin_oe_o && !diag_a_pin_o;
	endproperty
	a_diag_a_oc: assert property (p_diag_a_oc) else $error("diag a open drain wrong");
	a_diag_a_pp: assert property (p_diag_a_pp) else $error("diag a push pull wrong");
	a_diag_b_oc: assert property (p_diag_b_oc) else $error("diag b open drain wrong");
	a_diag_b_pp: assert property (p_diag_b_pp) else $error("diag b push pull wrong");
	a_halt: assert property (p_halt) else $error("sequencer halt wrong");
	a_drv_off: assert property (p_drv_off) else $error("driver not disabled");
	a_direct: assert property (p_direct) else $error("direct mode outputs wrong");
	a_uv_read: assert property (p_uv_read) else $error("undervolt flag not read");
	a_rst_diag: assert property (p_rst_diag) else $error("diag a not active in reset");
	c_status_rd: cover property (rd_i && addr_i == `GCS_ADDR_STATUS);
	c_direct: cover property (direct_mode_o);
	c_halt: cover property (seq_halt_o);
endmodule

// *** gcs_pin_board.sv ***
// board side of the diagnostic pins: pull-ups on the open-collector lines
module gcs_pin_board (
	input  wire logic a_o_i,
	input  wire logic a_oe_i,
	input  wire logic b_o_i,
	input  wire logic b_oe_i,
	output wire logic a_lvl_o,
	output wire logic b_lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// released line floats up, so an idle open collector reads high
	assign a_lvl_o = a_oe_i ? a_o_i : 1'b1;
	assign b_lvl_o = b_oe_i ? b_o_i : 1'b1;
endmodule

// *** test_gcs_regs.sv ***
// self-checking bench for the global config/status bank
`include "gcs_defines.vh"

module test_gcs_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, uart_mode_i = 1'b0;
	logic uart_wr_done_i = 1'b0, overtemp_i = 1'b0, short_i = 1'b0, pump_undervolt_i = 1'b0;
	logic diag_a_event_i = 1'b0, diag_b_event_i = 1'b0, enc_a_step_in_pin_i = 1'b0;
	logic [`GCS_ADDR_W-1:0] addr_i = 7'h00;
	logic [31:0] wdata_i = 32'h0, target_position_i = 32'h0, rdata_o;
	logic [`GCS_HOLD_W-1:0] hold_current_i = 5'h00;
	logic [`GCS_FREQ_W-1:0] step_freq_i = 20'h0, freq_thresh_i = 20'h00100;
	logic [3:0] test_signals_i = 4'h4;
	logic diag_a_pin_o, diag_a_pin_oe_o, diag_b_pin_o, diag_b_pin_oe_o, freq_above_o;
	logic seq_halt_o, driver_enable_o, direct_mode_o, auto_current_en_o;
	logic enc_n_dc_out_pin_o, enc_n_dc_out_pin_oe_o, diag_a_lvl, diag_b_lvl;
	logic [`GCS_COIL_W-1:0] coil_a_o, coil_b_o;
	logic [`GCS_CFG_W-1:0] global_config_flags_o;
	int n_errors = 0, cmp_count = 0;
	always #5 clk_i = ~clk_i;
	gcs_regs i_gcs_regs (
		.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .uart_mode_i(uart_mode_i),
		.uart_wr_done_i(uart_wr_done_i), .overtemp_i(overtemp_i), .short_i(short_i),
		.pump_undervolt_i(pump_undervolt_i), .diag_a_event_i(diag_a_event_i),
		.diag_b_event_i(diag_b_event_i), .enc_a_step_in_pin_i(enc_a_step_in_pin_i),
		.target_position_i(target_position_i), .hold_current_i(hold_current_i),
		.step_freq_i(step_freq_i), .freq_thresh_i(freq_thresh_i),
		.test_signals_i(test_signals_i), .diag_a_pin_o(diag_a_pin_o),
		.diag_a_pin_oe_o(diag_a_pin_oe_o), .diag_b_pin_o(diag_b_pin_o),
		.diag_b_pin_oe_o(diag_b_pin_oe_o), .freq_above_o(freq_above_o),
		.seq_halt_o(seq_halt_o), .driver_enable_o(driver_enable_o),
		.direct_mode_o(direct_mode_o), .auto_current_en_o(auto_current_en_o),
		.coil_a_o(coil_a_o), .coil_b_o(coil_b_o), .enc_n_dc_out_pin_o(enc_n_dc_out_pin_o),
		.enc_n_dc_out_pin_oe_o(enc_n_dc_out_pin_oe_o),
		.global_config_flags_o(global_config_flags_o)
	);
	gcs_pin_board i_gcs_pin_board (.a_o_i(diag_a_pin_o), .a_oe_i(diag_a_pin_oe_o),
		.b_o_i(diag_b_pin_o), .b_oe_i(diag_b_pin_oe_o), .a_lvl_o(diag_a_lvl), .b_lvl_o(diag_b_lvl));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [31:0] exp, input string nm);
		@(negedge clk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		chk(nm, rdata_o, exp);
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(negedge clk_i);
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			@(negedge clk_i);
			uart_wr_done_i = 1'b1;
			@(negedge clk_i);
			uart_wr_done_i = 1'b0;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		#100us;
		n_errors++;
		tally_and_finish;
	end
	initial begin
		step(10);
		chk("diag a reset", {diag_a_pin_oe_o, diag_a_pin_o}, 2'b10);
		nrst_i = 1'b1;
		rdc(`GCS_ADDR_CONFIG, 0, "config");
		rdc(`GCS_ADDR_STATUS, 1, "status");
		rdc(`GCS_ADDR_STATUS, 0, "status reread");
		wr(`GCS_ADDR_STATUS, 32'h7);
		wr(`GCS_ADDR_UARTCNT, 32'h5);
		rdc(`GCS_ADDR_STATUS, 0, "status ro");
		rdc(`GCS_ADDR_UARTCNT, 0, "count ro");
		uart_mode_i = 1'b1;
		pulse(255);
		rdc(`GCS_ADDR_UARTCNT, 32'hff, "count max");
		rdc(`GCS_ADDR_UARTCNT, 32'hff, "count reread");
		// follows a nonzero read so a stale read register would show
		rdc(7'h7f, 0, "unmapped");
		pulse(1);
		rdc(`GCS_ADDR_UARTCNT, 0, "count wrap");
		uart_mode_i = 1'b0;
		pulse(1);
		rdc(`GCS_ADDR_UARTCNT, 0, "count spi");
		overtemp_i = 1'b1;
		step(2);
		rdc(`GCS_ADDR_STATUS, 2, "drv err");
		rdc(`GCS_ADDR_STATUS, 2, "drv err held");
		overtemp_i = 1'b0;
		rdc(`GCS_ADDR_STATUS, 2, "drv err last");
		rdc(`GCS_ADDR_STATUS, 0, "drv err gone");
		pump_undervolt_i = 1'b1;
		step(2);
		chk("drv enable uv", driver_enable_o, 0);
		rdc(`GCS_ADDR_STATUS, 4, "undervolt");
		pump_undervolt_i = 1'b0;
		// still high at the last read edge, so the set won over the clear
		rdc(`GCS_ADDR_STATUS, 4, "undervolt last");
		rdc(`GCS_ADDR_STATUS, 0, "undervolt gone");
		chk("drv enable", driver_enable_o, 1);
		diag_a_event_i = 1'b1;
		diag_b_event_i = 1'b1;
		step(2);
		chk("diag oc active", {diag_a_lvl, diag_b_lvl}, 0);
		wr(`GCS_ADDR_CONFIG, 32'h3000);
		step(2);
		chk("diag pp active", {diag_a_lvl, diag_b_lvl}, 3);
		diag_a_event_i = 1'b0;
		diag_b_event_i = 1'b0;
		step(2);
		chk("diag pp idle", {diag_a_lvl, diag_b_lvl}, 0);
		// threshold 0x100: wide band ends at 0x110, narrow at 0x108
		wr(`GCS_ADDR_CONFIG, 0);
		step_freq_i = 20'h0010c;
		step(3);
		chk("wide hyst", freq_above_o, 0);
		wr(`GCS_ADDR_CONFIG, 32'h4000);
		step(3);
		chk("narrow hyst", freq_above_o, 1);
		wr(`GCS_ADDR_CONFIG, 32'h8000);
		enc_a_step_in_pin_i = 1'b1;
		step(2);
		chk("halt", seq_halt_o, 1);
		hold_current_i = 5'h10;
		target_position_i = 32'h01f0_0010;
		wr(`GCS_ADDR_CONFIG, 32'h10000);
		step(2);
		chk("halt off", seq_halt_o, 0);
		chk("direct", {direct_mode_o, auto_current_en_o}, 2'b10);
		chk("coil a", coil_a_o, 9'h008);
		chk("coil b", coil_b_o, 9'h1f8);
		// test output set on purpose, a host normally keeps it clear
		hold_current_i = 5'h12;
		wr(`GCS_ADDR_CONFIG, 32'h20000);
		step(2);
		chk("test out", {enc_n_dc_out_pin_oe_o, enc_n_dc_out_pin_o}, 2'b11);
		rdc(`GCS_ADDR_CONFIG, 32'h20000, "config rd");
		tally_and_finish;
	end
endmodule

bind gcs_regs gcs_regs_chk i_gcs_regs_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
	.pump_undervolt_i(pump_undervolt_i), .diag_a_event_i(diag_a_event_i),
	.diag_b_event_i(diag_b_event_i), .enc_a_step_in_pin_i(enc_a_step_in_pin_i),
	.diag_a_pin_o(diag_a_pin_o), .diag_a_pin_oe_o(diag_a_pin_oe_o),
	.diag_b_pin_o(diag_b_pin_o), .diag_b_pin_oe_o(diag_b_pin_oe_o),
	.seq_halt_o(seq_halt_o), .driver_enable_o(driver_enable_o),
	.direct_mode_o(direct_mode_o), .auto_current_en_o(auto_current_en_o),
	.rdata_o(rdata_o), .global_config_flags_o(global_config_flags_o)
);
